// ---- drive_far_side.sv ----
// Far-side model: network link and restart button of the drive controller
`timescale 1ns/10ps
`default_nettype none
module drive_far_side (
  input  wire logic clk_i,
  input  wire logic link_up_i,
  input  wire logic press_i,
  output logic      net_ok_o,
  output logic      restart_ack_o
);
  logic [3:0] hold_q = 4'h0;
  // Held eight cycles so the pulse survives the three-flop sync
  always @(posedge clk_i) begin
    net_ok_o <= link_up_i;
    if (press_i) begin
      hold_q <= 4'h8;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  assign restart_ack_o = (hold_q != 4'h0);
endmodule : drive_far_side
`default_nettype wire

// ---- drive_safety_monitor_config.sv ----
// Safety monitor of one drive axis with a classic Wishbone register slave
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
module drive_safety_monitor_config
  import safety_mon_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire wb_req_s     wb_i,
  output wb_rsp_s          wb_o,
  input  wire logic        net_ok_i,
  input  wire logic        restart_ack_i,
  input  wire logic [31:0] speed_abs_i,
  input  wire logic [31:0] lag_abs_i,
  input  wire logic [31:0] speed_err_abs_i,
  input  wire logic [31:0] set_pos_i,
  input  wire logic [31:0] act_pos_i,
  input  wire logic [3:0]  sls_active_i,
  input  wire logic        sos_active_i,
  output logic             safe_torque_off_o,
  output logic             controlled_stop_torque_off_o,
  output logic             safe_brake_control_o,
  output logic             operational_o,
  output logic             fail_safe_o
);

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : wmask

  function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff

  st_s q;
  st_s n;
  logic [3:0]        sls_over;
  logic [3:0]        sls_bad;
  logic              order_bad;
  logic              tick;
  logic              frozen;
  logic              dlyd;
  logic              taken;
  logic [31:0]       drift;
  logic [NCAUSE-1:0] v;

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_sls
      assign sls_over[k] = sls_active_i[k] && (speed_abs_i > q.safely_limited_speed[k]); // [R11]
      if (k == 3) begin : g_low
        assign sls_bad[k] = q.sos_spd > q.safely_limited_speed[k];
      end else begin : g_mid
        assign sls_bad[k] = q.safely_limited_speed[k+1] > q.safely_limited_speed[k];
      end
    end
  endgenerate

  // Bad ordering is only acted on at the leave-inhibit step, so software can
  // rewrite limits in any order while the axis is held
  assign order_bad = (|sls_bad) || (q.safely_limited_speed[0] > q.max_spd) || (q.max_spd > q.ceil); // [R12]
  assign tick      = (q.div == DIV_W'(US_CYC - 1));
  assign frozen    = (q.alive_cnt == ALIVE_W'(ALIVE_US));
  assign dlyd      = q.ctrl[B_DLYD];
  assign taken     = wb_i.cyc && wb_i.stb && !q.wb_ack;
  assign drift     = absdiff(act_pos_i, q.sos_ref);

  always_comb begin
    v          = '0;
    v[C_POS]   = q.ctrl[B_POS] && (lag_abs_i > q.enc_pos); // [R3] [R15]
    v[C_SPD]   = q.ctrl[B_SPD] && (speed_err_abs_i > q.enc_spd); // [R4] [R15]
    v[C_ALIVE] = q.ctrl[B_ALIVE] && frozen; // [R5]
    v[C_MAX]   = speed_abs_i > q.max_spd; // [R10]
    v[C_SLS]   = |sls_over; // [R11]
    v[C_SOS]   = sos_active_i && q.sos_prev &&
                 ((speed_abs_i > q.sos_spd) || (drift > q.pos_tol)); // [R13] [R14]
  end

  always_comb begin
    n          = q;
    n.net_s    = {q.net_s[1:0], net_ok_i};
    n.ack_s    = {q.ack_s[1:0], restart_ack_i};
    if (q.net_s[1] == q.net_s[2]) n.net_f = q.net_s[2];
    if (q.ack_s[1] == q.ack_s[2]) n.ack_f = q.ack_s[2];
    n.ack_prev = q.ack_f;
    n.div      = tick ? '0 : q.div + 1'b1;
    n.sos_prev = sos_active_i;
    if (sos_active_i && !q.sos_prev) n.sos_ref = act_pos_i; // [R14]
    // Alive check only counts while operational, so a held axis never trips it
    n.set_prev = set_pos_i;
    if (q.mode != OPER || set_pos_i != q.set_prev) begin
      n.alive_cnt = '0;
    end else if (tick && !frozen) begin
      n.alive_cnt = q.alive_cnt + 1'b1; // [R5]
    end
    if (q.mode == STOP1 && tick) n.sto_cnt = q.sto_cnt + 1'b1; // [R8]
    if ((q.mode == STOP1 || q.mode == FAIL) && tick && q.brk_cnt < q.brk_dly) begin
      n.brk_cnt = q.brk_cnt + 1'b1; // [R9]
    end

    unique case (q.mode)
      INHIBIT: begin
        if (q.net_f && (q.ctrl[B_AUTO] || (q.ack_f && !q.ack_prev))) begin // [R1] [R2]
          if (order_bad) begin
            n.cause[C_ORDER] = 1'b1; // [R12]
            n.mode           = FAIL;
          end else begin
            n.mode = OPER;
          end
        end
      end
      OPER: begin
        if (|v) begin
          n.cause   = q.cause | v; // [R16]
          n.div     = '0;
          n.sto_cnt = '0;
          n.brk_cnt = '0;
          n.mode    = dlyd ? STOP1 : FAIL; // [R6] [R7]
        end else if (!q.net_f) begin
          n.mode = INHIBIT; // [R1]
        end
      end
      STOP1: begin
        if (q.sto_cnt >= q.sto_dly) n.mode = FAIL; // [R7] [R8]
      end
      FAIL: begin
        n.mode = FAIL; // [R16]
      end
    endcase

    n.safe_torque_off   = (n.mode == INHIBIT) || (n.mode == FAIL); // [R6]
    n.stop1 = (n.mode == STOP1) || (n.mode == FAIL); // [R7]
    n.op    = (n.mode == OPER); // [R2]
    unique case (n.mode)
      INHIBIT: n.brake = 1'b1;
      OPER:    n.brake = 1'b0; // [R2]
      STOP1:   n.brake = dlyd && (n.brk_cnt >= q.brk_dly); // [R9]
      FAIL:    n.brake = !dlyd || (n.brk_cnt >= q.brk_dly); // [R6] [R9]
    endcase

    n.wb_ack = taken;
    if (taken) begin
      n.wb_dat = '0;
      unique case (wb_i.adr)
        A_CTRL:    n.wb_dat = 32'(q.ctrl);
        A_STO_DLY: n.wb_dat = q.sto_dly;
        A_BRK_DLY: n.wb_dat = q.brk_dly;
        A_MAX:     n.wb_dat = q.max_spd;
        A_SOS_SPD: n.wb_dat = q.sos_spd;
        A_POS_TOL: n.wb_dat = q.pos_tol;
        A_ENC_POS: n.wb_dat = q.enc_pos;
        A_ENC_SPD: n.wb_dat = q.enc_spd;
        A_CEIL:    n.wb_dat = q.ceil;
        A_STAT: begin
          n.wb_dat[S_CAUSE +: NCAUSE] = q.cause;
          n.wb_dat[4:0] = {q.net_f, q.mode == INHIBIT, q.stop1, q.mode == FAIL, q.op};
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_i.adr == A_SLS1 + 8'(4 * i)) n.wb_dat = q.safely_limited_speed[i];
          end
        end
      endcase
      if (wb_i.we) begin
        unique case (wb_i.adr)
          A_CTRL:    n.ctrl    = CW'(wmask(32'(q.ctrl), wb_i.dat, wb_i.sel)); // [R3] [R4]
          A_STO_DLY: n.sto_dly = wmask(q.sto_dly, wb_i.dat, wb_i.sel); // [R8]
          A_BRK_DLY: n.brk_dly = wmask(q.brk_dly, wb_i.dat, wb_i.sel); // [R9]
          A_MAX:     n.max_spd = wmask(q.max_spd, wb_i.dat, wb_i.sel); // [R10]
          A_SOS_SPD: n.sos_spd = wmask(q.sos_spd, wb_i.dat, wb_i.sel); // [R13]
          A_POS_TOL: n.pos_tol = wmask(q.pos_tol, wb_i.dat, wb_i.sel); // [R14]
          A_ENC_POS: n.enc_pos = wmask(q.enc_pos, wb_i.dat, wb_i.sel); // [R15]
          A_ENC_SPD: n.enc_spd = wmask(q.enc_spd, wb_i.dat, wb_i.sel); // [R15]
          A_CEIL:    n.ceil    = wmask(q.ceil, wb_i.dat, wb_i.sel);
          default: begin
            for (int i = 0; i < 4; i++) begin
              if (wb_i.adr == A_SLS1 + 8'(4 * i)) begin
                n.safely_limited_speed[i] = wmask(q.safely_limited_speed[i], wb_i.dat, wb_i.sel); // [R11]
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q         <= '0;
      q.mode    <= INHIBIT;
      q.ctrl    <= CTRL_RST; // [R3] [R4] [R5]
      q.sto_dly <= LIM_RST;
      q.brk_dly <= LIM_RST;
      q.max_spd <= LIM_RST;
      q.safely_limited_speed     <= '0;
      q.ceil    <= CEIL_RST;
      q.safe_torque_off     <= 1'b1;
      q.brake   <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign wb_o.ack                     = q.wb_ack;
  assign wb_o.dat                     = q.wb_dat;
  assign safe_torque_off_o            = q.safe_torque_off;
  assign controlled_stop_torque_off_o = q.stop1;
  assign safe_brake_control_o         = q.brake;
  assign operational_o                = q.op;
  assign fail_safe_o                  = (q.mode == FAIL) || (q.mode == STOP1);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_trip;
    q.mode == OPER && (|v);
  endsequence
  sequence s_stop_phase;
    q.mode == STOP1 && q.stop1 && !q.safe_torque_off;
  endsequence

  property p_auto_restart;
    q.mode == INHIBIT && q.net_f && q.ctrl[B_AUTO] && !order_bad
      |=> q.op && !q.safe_torque_off && !q.brake;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("auto restart failed"); // [R2]
  property p_net_loss;
    q.mode == OPER && !q.net_f && !(|v) |=> q.mode == INHIBIT && q.safe_torque_off && !q.op;
  endproperty
  a_net_loss: assert property (p_net_loss) else $error("no inhibit on net loss"); // [R1]
  property p_pos_off;
    !q.ctrl[B_POS] && !q.cause[C_POS] |=> !q.cause[C_POS];
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("disabled lag monitor tripped"); // [R3]
  property p_spd_on;
    q.mode == OPER && q.ctrl[B_SPD] && speed_err_abs_i > q.enc_spd |=> q.cause[C_SPD];
  endproperty
  a_spd_on: assert property (p_spd_on) else $error("speed error missed"); // [R4]
  property p_alive_off;
    !q.ctrl[B_ALIVE] && !q.cause[C_ALIVE] |=> !q.cause[C_ALIVE];
  endproperty
  a_alive_off: assert property (p_alive_off) else $error("disabled alive check tripped"); // [R5]
  property p_immediate;
    s_trip and !dlyd |=> q.safe_torque_off && q.brake && q.mode == FAIL;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate reaction wrong"); // [R6]
  property p_delayed;
    s_trip and dlyd |=> s_stop_phase;
  endproperty
  a_delayed: assert property (p_delayed) else $error("controlled stop stage missing"); // [R7]
  property p_sto_delay;
    q.mode == STOP1 && q.sto_cnt >= q.sto_dly |=> q.safe_torque_off && q.stop1 && q.mode == FAIL;
  endproperty
  a_sto_delay: assert property (p_sto_delay) else $error("delayed torque-off late"); // [R8]
  property p_brake_hold;
    q.mode == STOP1 && q.brk_cnt < q.brk_dly && $stable(q.brk_dly) |-> !q.brake;
  endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("brake engaged too early"); // [R9]
  property p_max;
    q.mode == OPER && speed_abs_i > q.max_spd |=> q.cause[C_MAX] && q.mode != OPER;
  endproperty
  a_max: assert property (p_max) else $error("max speed missed"); // [R10]
  property p_sls;
    q.mode == OPER && (|sls_over) |=> q.cause[C_SLS];
  endproperty
  a_sls: assert property (p_sls) else $error("limited speed missed"); // [R11]
  property p_order;
    q.mode == INHIBIT && q.net_f && q.ctrl[B_AUTO] && order_bad
      |=> q.mode == FAIL && q.cause[C_ORDER];
  endproperty
  a_order: assert property (p_order) else $error("limit order not enforced"); // [R12]
  property p_sos;
    q.mode == OPER && sos_active_i && q.sos_prev && drift > q.pos_tol |=> q.cause[C_SOS];
  endproperty
  a_sos: assert property (p_sos) else $error("standstill drift missed"); // [R14]
  property p_fail_hold;
    q.mode == FAIL |=> q.mode == FAIL [*2];
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail safe left"); // [R16]

endmodule : drive_safety_monitor_config
`default_nettype wire

// ---- drive_safety_monitor_config_tb.sv ----
// Self-checking bench of the drive safety monitor
`timescale 1ns/10ps
`default_nettype none
module drive_safety_monitor_config_tb;
  import safety_mon_pkg::*;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  wb_req_s     req     = '0;
  wb_rsp_s     rsp;
  logic        link_up = 1'b1;
  logic        press   = 1'b0;
  logic        net_ok;
  logic        rack;
  logic [31:0] speed   = 32'h0;
  logic [31:0] lag     = 32'h0;
  logic [31:0] serr    = 32'h0;
  logic [31:0] act     = 32'h0;
  logic [3:0]  sls_on  = 4'h0;
  logic        sos_on  = 1'b0;
  logic        safe_torque_off;
  logic        stop1;
  logic        brake;
  logic        op;
  logic        fsafe;
  logic [31:0] rdat;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #5 clk = ~clk;

  drive_far_side far_u (.clk_i(clk), .link_up_i(link_up), .press_i(press),
                        .net_ok_o(net_ok), .restart_ack_o(rack));
  drive_safety_monitor_config dut_u (
    .clk_i(clk), .rst_i(rst), .wb_i(req), .wb_o(rsp), .net_ok_i(net_ok),
    .restart_ack_i(rack), .speed_abs_i(speed), .lag_abs_i(lag), .speed_err_abs_i(serr),
    .set_pos_i(32'h0), .act_pos_i(act), .sls_active_i(sls_on), .sos_active_i(sos_on),
    .safe_torque_off_o(safe_torque_off), .controlled_stop_torque_off_o(stop1),
    .safe_brake_control_o(brake), .operational_o(op), .fail_safe_o(fsafe));

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Run is under a thousand cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Checks land on the falling edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    do @(negedge clk); while (rsp.ack !== 1'b1);
    rdat = rsp.dat;
    @(posedge clk);
    req <= '0;
  endtask : bus

  task automatic restart_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : restart_dut

  task automatic t_defaults();
    for (int i = 0; i < 13; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk(rdat, (i == 0) ? 32'h6 : (i == 12) ? 32'hffffffff : 32'h0);
    end
    bus(1'b1, 8'h3c, 32'h5a);
    bus(1'b0, 8'h3c, 32'h0);
    chk(rdat, 32'h0);
    chk(32'({safe_torque_off, brake, op}), 32'h6);
  endtask : t_defaults

  task automatic t_restart();
    tick(20);
    chk(32'(op), 32'h0);
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    tick(12);
    chk(32'({op, safe_torque_off, brake}), 32'h4);
    @(posedge clk);
    link_up <= 1'b0;
    tick(8);
    chk(32'(op), 32'h0);
    @(posedge clk);
    link_up <= 1'b1;
    tick(12);
    chk(32'(op), 32'h0);
    bus(1'b1, A_CTRL, 32'h7);
    tick(12);
    chk(32'({op, safe_torque_off, brake}), 32'h4);
    @(posedge clk);
    link_up <= 1'b0;
    tick(8);
    @(posedge clk);
    link_up <= 1'b1;
    tick(12);
    chk(32'(op), 32'h1);
  endtask : t_restart

  task automatic t_immediate();
    bus(1'b1, A_MAX, 32'd100);
    @(posedge clk);
    speed <= 32'd100;
    tick(3);
    chk(32'(op), 32'h1);
    @(posedge clk);
    speed <= 32'd101;
    tick(2);
    chk(32'({safe_torque_off, brake, stop1, fsafe, op}), 32'h1e);
    @(posedge clk);
    speed <= 32'd0;
    tick(5);
    bus(1'b0, A_STAT, 32'h0);
    chk(32'({fsafe, rdat[11]}), 32'h3);
  endtask : t_immediate

  task automatic t_delayed();
    restart_dut();
    bus(1'b1, A_STO_DLY, 32'd2);
    bus(1'b1, A_BRK_DLY, 32'd1);
    bus(1'b1, A_MAX, 32'd100);
    bus(1'b1, A_CTRL, 32'h17);
    tick(12);
    @(posedge clk);
    speed <= 32'd101;
    tick(3);
    chk(32'({safe_torque_off, stop1, brake, fsafe}), 32'h5);
    tick(80);
    chk(32'({safe_torque_off, brake}), 32'h0);
    tick(40);
    chk(32'({safe_torque_off, brake}), 32'h1);
    tick(60);
    chk(32'(safe_torque_off), 32'h0);
    tick(40);
    chk(32'({safe_torque_off, brake, fsafe}), 32'h7);
    @(posedge clk);
    speed <= 32'd0;
  endtask : t_delayed

  // Limited level above maximum breaks the ordering
  task automatic t_order();
    restart_dut();
    bus(1'b1, A_SLS1, 32'd200);
    bus(1'b1, A_CTRL, 32'h7);
    tick(12);
    chk(32'({op, fsafe}), 32'h1);
  endtask : t_order

  task automatic t_limited(input int k);
    restart_dut();
    bus(1'b1, A_MAX, 32'd100);
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, 8'(A_SLS1 + 4 * j), 32'd50);
    end
    bus(1'b1, A_CTRL, 32'h7);
    tick(12);
    @(posedge clk);
    speed <= 32'd51;
    tick(3);
    chk(32'(op), 32'h1);
    @(posedge clk);
    sls_on <= 4'(1 << k);
    tick(3);
    bus(1'b0, A_STAT, 32'h0);
    chk(32'({fsafe, rdat[12]}), 32'h3);
    @(posedge clk);
    sls_on <= 4'h0;
    speed <= 32'd0;
  endtask : t_limited

  task automatic t_encoder(input logic [31:0] en, input logic [31:0] cause);
    restart_dut();
    bus(1'b1, A_ENC_POS, 32'ha);
    bus(1'b1, A_ENC_SPD, 32'ha);
    bus(1'b1, A_CTRL, 32'h1);
    @(posedge clk);
    lag <= 32'd11;
    serr <= 32'd11;
    tick(12);
    chk(32'(op), 32'h1);
    bus(1'b1, A_CTRL, en);
    tick(3);
    bus(1'b0, A_STAT, 32'h0);
    chk(32'(rdat[14:8]), cause);
  endtask : t_encoder

  task automatic t_standstill();
    restart_dut();
    bus(1'b1, A_POS_TOL, 32'd10);
    bus(1'b1, A_CTRL, 32'h7);
    @(posedge clk);
    act <= 32'd1000;
    tick(12);
    @(posedge clk);
    sos_on <= 1'b1;
    @(posedge clk);
    act <= 32'd1010;
    tick(3);
    chk(32'(op), 32'h1);
    @(posedge clk);
    act <= 32'd1011;
    tick(3);
    bus(1'b0, A_STAT, 32'h0);
    chk(32'({fsafe, rdat[13]}), 32'h3);
  endtask : t_standstill

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_restart();
    t_immediate();
    t_delayed();
    t_order();
    for (int k = 0; k < 4; k++) begin
      t_limited(k);
    end
    t_encoder(32'h3, 32'h1);
    t_encoder(32'h5, 32'h2);
    @(posedge clk);
    lag <= 32'd0;
    serr <= 32'd0;
    t_standstill();
    give_verdict();
  end
endmodule : drive_safety_monitor_config_tb
`default_nettype wire

// ---- safety_mon_pkg.sv ----
// Constants, register map and types of the drive safety monitor
// How it works
// [R1] Auto-restart bit chooses whether restart waits for acknowledge after startup or network loss.
// [R2] With auto-restart, go operational alone: torque-off and brake released.
// [R3] Position-lag monitor, on after reset, can be switched off by software.
// [R4] Speed-error monitor, on by default, checks only while enabled.
// [R5] Frozen set-position check, off by default.
// [R6] Immediate reaction: torque-off and brake together at fail-safe entry.
// [R7] Delayed reaction: controlled-stop torque-off first, full torque-off after delay.
// [R8] Controlled-stop to torque-off delay is a microsecond count, reset zero.
// [R9] Brake delay in microseconds, reset zero, gates brake in delayed reaction.
// [R10] Maximum speed limit register, reset zero, trips monitor when exceeded.
// [R11] Four limited-speed thresholds, reset zero, each checked when selected.
// [R12] Limits must be ordered; otherwise fail safe at the startup transition.
// [R13] Standstill holds only while speed stays within speed tolerance.
// [R14] Standstill movement checked against one position tolerance, reset zero.
// [R15] Encoder lag and speed errors each have their own tolerance.
// [R16] Any enabled violation enters fail safe and applies the chosen reaction.
package safety_mon_pkg;
  localparam int unsigned CLK_NS   = 10;
  localparam int unsigned US_NS    = 1000;
  localparam int unsigned US_CYC   = US_NS / CLK_NS;
  localparam int unsigned DIV_W    = 7;
  localparam int unsigned ALIVE_US = 1000;
  localparam int unsigned ALIVE_W  = 10;
  localparam int unsigned CW       = 5;
  localparam int unsigned NCAUSE   = 7;

  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STO_DLY = 8'h04;
  localparam logic [7:0] A_BRK_DLY = 8'h08;
  localparam logic [7:0] A_MAX     = 8'h0c;
  localparam logic [7:0] A_SLS1    = 8'h10;
  localparam logic [7:0] A_SOS_SPD = 8'h20;
  localparam logic [7:0] A_POS_TOL = 8'h24;
  localparam logic [7:0] A_ENC_POS = 8'h28;
  localparam logic [7:0] A_ENC_SPD = 8'h2c;
  localparam logic [7:0] A_CEIL    = 8'h30;
  localparam logic [7:0] A_STAT    = 8'h34;

  localparam int unsigned B_AUTO  = 0;
  localparam int unsigned B_POS   = 1;
  localparam int unsigned B_SPD   = 2;
  localparam int unsigned B_ALIVE = 3;
  localparam int unsigned B_DLYD  = 4;
  localparam logic [CW-1:0] CTRL_RST = 5'h06;
  localparam logic [31:0]   LIM_RST  = 32'h0;
  localparam logic [31:0]   CEIL_RST = 32'hffffffff;

  localparam int unsigned C_POS   = 0;
  localparam int unsigned C_SPD   = 1;
  localparam int unsigned C_ALIVE = 2;
  localparam int unsigned C_MAX   = 3;
  localparam int unsigned C_SLS   = 4;
  localparam int unsigned C_SOS   = 5;
  localparam int unsigned C_ORDER = 6;
  localparam int unsigned S_CAUSE = 8;

  typedef enum logic [1:0] {INHIBIT, OPER, STOP1, FAIL} mode_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    mode_e             mode;
    logic [CW-1:0]     ctrl;
    logic [31:0]       sto_dly;
    logic [31:0]       brk_dly;
    logic [31:0]       max_spd;
    logic [3:0][31:0]  safely_limited_speed;
    logic [31:0]       sos_spd;
    logic [31:0]       pos_tol;
    logic [31:0]       enc_pos;
    logic [31:0]       enc_spd;
    logic [31:0]       ceil;
    logic [NCAUSE-1:0] cause;
    logic [2:0]        net_s;
    logic [2:0]        ack_s;
    logic              net_f;
    logic              ack_f;
    logic              ack_prev;
    logic [DIV_W-1:0]  div;
    logic [31:0]       sto_cnt;
    logic [31:0]       brk_cnt;
    logic [31:0]       set_prev;
    logic [ALIVE_W-1:0] alive_cnt;
    logic [31:0]       sos_ref;
    logic              sos_prev;
    logic              safe_torque_off;
    logic              stop1;
    logic              brake;
    logic              op;
    logic              wb_ack;
    logic [31:0]       wb_dat;
  } st_s;
endpackage : safety_mon_pkg
